// ---- cmr_bus_node.sv ----
// Other CAN node on the bus: idles recessive, sends a burst of toggling bits on command
`timescale 1ns/10ps
module cmr_bus_node #(
  parameter int BIT_CYC = 4          // Clock cycles per bit
)(
  input wire logic clk_i,            // Bench clock
  input wire logic rst_i,            // Synchronous reset
  input wire logic tx_pin_i,         // Transmit pin of the block
  input wire logic start_i,          // Begin a burst
  input wire logic [7:0] bits_i,     // Burst length in bits
  output logic rx_o,                 // Bus level, 1 recessive
  output logic busy_o                // Burst in progress
);
  logic drv_q;                       // Own drive, 1 recessive
  int left_q;                        // Bits still to send
  int cyc_q;                         // Cycle within the bit
  // Drives only when told, so a burst is the only activity the block sees
  always_ff @(posedge clk_i)
  begin
    if (rst_i || (left_q == 0 && !start_i))
    begin
      drv_q <= 1'b1;
      left_q <= 0;
      cyc_q <= 0;
    end
    else if (left_q == 0)
    begin
      left_q <= int'(bits_i);
      drv_q <= 1'b0;
      cyc_q <= 0;
    end
    else if (cyc_q == BIT_CYC - 1)
    begin
      left_q <= left_q - 1;
      drv_q <= (left_q == 1) ? 1'b1 : ~drv_q;
      cyc_q <= 0;
    end
    else
      cyc_q <= cyc_q + 1;
  end
  // Wired-AND: recessive unless some party pulls it dominant
  assign rx_o = tx_pin_i & drv_q;
  assign busy_o = (left_q != 0);
endmodule

// ---- cmr_mode_ctrl.sv ----
// CAN controller mode-request logic with AHB-Lite register slave
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
// Overview of operation
// - Sleep only when receiver idle, buffers empty
// - Sleep entry sets sleep acknowledge
// - Sleep request refused while wake-up flag set
// - Sleep until cleared; bus activity may clear
// - Sleep clear ignored until sleep acknowledged
// - Init request aborts traffic, drops sync
// - Init entry sets init acknowledge
// - Init entry resets control and flag registers
// - Init keeps wake-up, requests, status fields
// - Config registers writable only in init mode
// - Error counters survive init entry and exit
// - Exit resync: 11 recessive, bus-off 128 times
// - Init clear ignored until init acknowledged
// - Init request forces transmit pin recessive
// - Stop, or wait with stop_in_wait, recessive
// - Control 0 bit1 sleep, bit0 init request
module cmr_mode_ctrl
  import cmr_pkg::*;
#(
  parameter int BIT_CYC = CMR_BIT_CYC      // Clock cycles per CAN bit
)(
  input wire logic SYS_CLK_I,              // System clock, 50 MHz
  input wire logic RST_I,                  // Synchronous reset, active high
  input wire logic HSEL_I,                 // AHB-Lite slave select
  input wire logic [31:0] HADDR_I,         // AHB-Lite address
  input wire logic [1:0] HTRANS_I,         // AHB-Lite transfer type
  input wire logic HWRITE_I,               // AHB-Lite write
  input wire logic [2:0] HSIZE_I,          // AHB-Lite size
  input wire logic [31:0] HWDATA_I,        // AHB-Lite write data
  input wire logic HREADY_I,               // AHB-Lite bus ready
  output logic [31:0] HRDATA_O,            // AHB-Lite read data
  output logic HREADYOUT_O,                // AHB-Lite slave ready
  output logic HRESP_O,                    // AHB-Lite response, always OKAY
  input wire logic BUS_RX_I,               // CAN receive pin, 1 = recessive
  input wire logic RX_BUSY_I,              // Core is receiving a message
  input wire logic BUS_OFF_I,              // Core is bus-off
  input wire logic [7:0] TX_ERR_CNT_I,     // Transmit error counter from core
  input wire logic [7:0] RX_ERR_CNT_I,     // Receive error counter from core
  input wire logic [7:0] TX_STAT_I,        // Tx/rx status fields from core (bits 5:2)
  input wire logic STOP_MODE_I,            // CPU is in stop mode
  input wire logic WAIT_MODE_I,            // CPU is in wait mode
  input wire logic TX_CORE_I,              // Transmit bit from protocol core
  output logic BUS_TX_PIN_O,               // CAN transmit pin, 1 = recessive
  output logic CORE_ABORT_O,               // Abort traffic and drop sync
  output logic CORE_RUN_O,                 // Core synchronized and running
  output logic SLEEP_O                     // Sleep mode active
);

  initial
  begin
    if (BIT_CYC < 2 || BIT_CYC > 65535)
      $error("BIT_CYC out of range");
  end

  // ==========================================================================
  // State
  typedef enum logic [3:0] {
    CMR_RUN = 4'b0001,     // Normal operation
    CMR_SLEEP = 4'b0010,   // Sleep mode
    CMR_INIT = 4'b0100,    // Initialization mode
    CMR_SYNC = 4'b1000     // Waiting for bus idle after init exit
  } cmr_mode_t;

  typedef struct packed {
    cmr_mode_t mode;
    logic [7:0] ctl0;
    logic [7:0] ctl1;
    logic [7:0] rxf;
    logic [7:0] rxie;
    logic [7:0] txf;
    logic [7:0] txie;
    logic [7:0] tarq;
    logic [7:0] taak;
    logic [7:0] tbsel;
    logic [7:0] bt0;
    logic [7:0] bt1;
    logic [7:0] idac;
    logic [63:0] idar;
    logic [63:0] idmr;
    logic [15:0] bdiv;     // Bit-time divider
    logic [3:0] rcnt;      // Consecutive recessive bits
    logic [7:0] runs;      // Idle runs while bus-off
    logic dph;             // Data phase pending
    logic dwr;             // Pending transfer is a write
    logic [7:0] daddr;     // Pending address
    logic [31:0] rdata;
  } cmr_state_t;

  cmr_state_t s_q;
  cmr_state_t s_d;

  // Register read mux, shared by read data
  function automatic logic [7:0] rd_reg(input cmr_state_t s, input logic [7:0] a,
                                        input logic [7:0] st, input logic [15:0] ec);
    logic [7:0] v;
    v = 8'h00;
    if (a == CMR_OFS_CTL0) v = s.ctl0;
    else if (a == CMR_OFS_CTL1) v = s.ctl1;
    else if (a == CMR_OFS_RXF) v = s.rxf;
    else if (a == CMR_OFS_RXIE) v = s.rxie;
    else if (a == CMR_OFS_TXF) v = s.txf;
    else if (a == CMR_OFS_TXIE) v = s.txie;
    else if (a == CMR_OFS_TARQ) v = s.tarq;
    else if (a == CMR_OFS_TAAK) v = s.taak;
    else if (a == CMR_OFS_TBSEL) v = s.tbsel;
    else if (a == CMR_OFS_BT0) v = s.bt0;
    else if (a == CMR_OFS_BT1) v = s.bt1;
    else if (a == CMR_OFS_IDAC) v = s.idac;
    else if (a[7:5] == CMR_OFS_IDAR[7:5]) v = s.idar[a[4:2]*8 +: 8];
    else if (a[7:5] == CMR_OFS_IDMR[7:5]) v = s.idmr[a[4:2]*8 +: 8];
    else if (a == CMR_OFS_STAT) v = st;
    return v;
  endfunction

  logic in_init;        // Init request and ack both set
  logic bus_idle;       // No reception and all buffers empty
  logic bit_tick;       // One pulse per CAN bit time
  logic [7:0] stat_v;   // Block status byte
  logic [15:0] err_v;   // Error counters, passed through untouched

  assign in_init = s_q.ctl0[CMR_B_INIT_REQUEST] && s_q.ctl1[CMR_B_INIT_ACK];
  assign bus_idle = !RX_BUSY_I && (s_q.txf[2:0] == 3'b111);
  assign bit_tick = (s_q.bdiv == 16'(BIT_CYC - 1));
  assign stat_v = {3'b000, s_q.mode == CMR_SYNC, s_q.mode == CMR_SLEEP, s_q.mode == CMR_INIT,
                   BUS_OFF_I, RX_BUSY_I};
  // Error counters are inputs from the core and never reset here
  assign err_v = {TX_ERR_CNT_I, RX_ERR_CNT_I};

  // ==========================================================================
  // Next-state logic
  always_comb
  begin
    logic [7:0] wd;
    logic wr;
    wd = HWDATA_I[7:0];
    s_d = s_q;
    wr = s_q.dph && s_q.dwr;
    // Bit-time divider; the recessive run counter is stepped in the sync state below
    s_d.bdiv = bit_tick ? 16'h0000 : s_q.bdiv + 16'h0001;
    // Write data phase
    if (wr)
    begin
      if (s_q.daddr == CMR_OFS_CTL0)
      begin
        // Sleep request: set refused while wake-up flag pending
        if (wd[CMR_B_SLEEP_REQUEST] && !s_q.rxf[CMR_B_WAKEUP_IRQ_FLAG])
          s_d.ctl0[CMR_B_SLEEP_REQUEST] = 1'b1;
        // Clear only once sleep acknowledged
        else if (!wd[CMR_B_SLEEP_REQUEST] && s_q.ctl1[CMR_B_SLEEP_ACK])
          s_d.ctl0[CMR_B_SLEEP_REQUEST] = 1'b0;
        // Init request: set anytime, clear only once acknowledged
        if (wd[CMR_B_INIT_REQUEST])
          s_d.ctl0[CMR_B_INIT_REQUEST] = 1'b1;
        else if (in_init)
          s_d.ctl0[CMR_B_INIT_REQUEST] = 1'b0;
        s_d.ctl0[7:2] = wd[7:2];
      end
      else if (s_q.daddr == CMR_OFS_RXF)
        s_d.rxf = s_q.rxf & ~wd;           // Write one to clear
      else if (s_q.daddr == CMR_OFS_RXIE)
        s_d.rxie = wd;
      else if (s_q.daddr == CMR_OFS_TXF)
        s_d.txf = s_q.txf | (wd & 8'h07);  // Software releases buffers by writing one
      else if (s_q.daddr == CMR_OFS_TXIE)
        s_d.txie = wd;
      else if (s_q.daddr == CMR_OFS_TARQ)
        s_d.tarq = wd;
      else if (s_q.daddr == CMR_OFS_TBSEL)
        s_d.tbsel = wd;
      // Configuration registers locked outside init mode
      else if (in_init)
      begin
        if (s_q.daddr == CMR_OFS_CTL1)
          s_d.ctl1[7:2] = wd[7:2];
        else if (s_q.daddr == CMR_OFS_BT0)
          s_d.bt0 = wd;
        else if (s_q.daddr == CMR_OFS_BT1)
          s_d.bt1 = wd;
        else if (s_q.daddr == CMR_OFS_IDAC)
          s_d.idac = wd;
        else if (s_q.daddr[7:5] == CMR_OFS_IDAR[7:5])
          s_d.idar[s_q.daddr[4:2]*8 +: 8] = wd;
        else if (s_q.daddr[7:5] == CMR_OFS_IDMR[7:5])
          s_d.idmr[s_q.daddr[4:2]*8 +: 8] = wd;
      end
    end
    // Mode sequencing
    case (s_q.mode)
      CMR_RUN:
      begin
        if (s_q.ctl0[CMR_B_INIT_REQUEST])
          s_d.mode = CMR_INIT;
        else if (s_q.ctl0[CMR_B_SLEEP_REQUEST] && bus_idle)
        begin
          s_d.mode = CMR_SLEEP;
          s_d.ctl1[CMR_B_SLEEP_ACK] = 1'b1;
        end
        else
          s_d.ctl1[CMR_B_SLEEP_ACK] = 1'b0;
      end
      CMR_SLEEP:
      begin
        if (s_q.ctl0[CMR_B_INIT_REQUEST])
          s_d.mode = CMR_INIT;
        else if (!s_q.ctl0[CMR_B_SLEEP_REQUEST])
          s_d.mode = CMR_RUN;
        else if (!BUS_RX_I && s_q.ctl0[CMR_B_WAKEUP_ENABLE])
        begin
          // Bus activity wakes us; flag set wins over any clear this cycle
          s_d.ctl0[CMR_B_SLEEP_REQUEST] = 1'b0;
          s_d.rxf[CMR_B_WAKEUP_IRQ_FLAG] = 1'b1;
          s_d.mode = CMR_RUN;
        end
      end
      CMR_INIT:
      begin
        // Hard-reset the listed registers, keeping wake-up, requests, status
        s_d.ctl0 = (CMR_RST_CTL0 & ~8'h07) | (s_d.ctl0 & 8'h07);
        s_d.rxf = (CMR_RST_ZERO & ~CMR_STAT_MASK) | (TX_STAT_I & CMR_STAT_MASK);
        s_d.rxie = CMR_RST_ZERO & ~CMR_STAT_MASK | (s_q.rxie & CMR_STAT_MASK);
        s_d.txf = CMR_RST_TXF;
        s_d.txie = CMR_RST_ZERO;
        s_d.tarq = CMR_RST_ZERO;
        s_d.taak = CMR_RST_ZERO;
        s_d.tbsel = CMR_RST_ZERO;
        s_d.ctl1[CMR_B_INIT_ACK] = 1'b1;
        s_d.ctl1[CMR_B_SLEEP_ACK] = 1'b0;
        if (!s_q.ctl0[CMR_B_INIT_REQUEST])
        begin
          s_d.mode = CMR_SYNC;
          s_d.ctl1[CMR_B_INIT_ACK] = 1'b0;
          s_d.rcnt = 4'h0;
          s_d.runs = 8'h00;
        end
      end
      CMR_SYNC:
      begin
        if (s_q.ctl0[CMR_B_INIT_REQUEST])
          s_d.mode = CMR_INIT;
        else if (bit_tick)
        begin
          // Count recessive bits; a dominant bit restarts the run
          if (!BUS_RX_I)
            s_d.rcnt = 4'h0;
          else if (s_q.rcnt == 4'(CMR_IDLE_BITS - 1))
          begin
            s_d.rcnt = 4'h0;
            if (!BUS_OFF_I || s_q.runs == 8'(CMR_BUSOFF_RUNS - 1))
              s_d.mode = CMR_RUN;
            else
              s_d.runs = s_q.runs + 8'h01;
          end
          else
            s_d.rcnt = s_q.rcnt + 4'h1;
        end
      end
      default:
        s_d.mode = CMR_RUN;
    endcase
    // Address phase capture
    if (HREADY_I)
    begin
      s_d.dph = HSEL_I && HTRANS_I[1];
      s_d.dwr = HWRITE_I;
      s_d.daddr = HADDR_I[7:0];
      s_d.rdata = {16'h0000, (HADDR_I[7:0] == CMR_OFS_STAT) ? err_v[15:8] : 8'h00,
                   rd_reg(s_q, HADDR_I[7:0], stat_v, err_v)};
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      s_q <= '0;
      s_q.mode <= CMR_INIT;
      s_q.ctl0 <= CMR_RST_CTL0 | 8'h01;   // Comes out of reset requesting init
      s_q.ctl1 <= CMR_RST_CTL1;
      s_q.txf <= CMR_RST_TXF;
    end
    else
      s_q <= s_d;
  end

  // ==========================================================================
  // Outputs
  assign HRDATA_O = s_q.rdata;
  assign HREADYOUT_O = 1'b1;    // Zero wait states
  assign HRESP_O = 1'b0;
  // Pin forced recessive on init request or low-power entry
  assign BUS_TX_PIN_O = s_q.ctl0[CMR_B_INIT_REQUEST] || STOP_MODE_I || (WAIT_MODE_I && s_q.ctl1[5])
                        || s_q.mode != CMR_RUN || TX_CORE_I;
  assign CORE_ABORT_O = s_q.ctl0[CMR_B_INIT_REQUEST] || s_q.mode == CMR_INIT;
  // A fresh init request stops the core in the same cycle it lands, not one later
  assign CORE_RUN_O = (s_q.mode == CMR_RUN) && !s_q.ctl0[CMR_B_INIT_REQUEST];
  assign SLEEP_O = s_q.mode == CMR_SLEEP;

endmodule

// ---- cmr_mode_ctrl_sva.sv ----
// Assertion checker bound to the CAN mode-request block
`timescale 1ns/10ps
module cmr_mode_ctrl_sva
  import cmr_pkg::*;
#(
  parameter int BIT_CYC = CMR_BIT_CYC  // Cycles per bit
)(
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic BUS_RX_I,
  input wire logic RX_BUSY_I,
  input wire logic [7:0] TX_ERR_CNT_I,
  input wire logic STOP_MODE_I,
  input wire logic WAIT_MODE_I,
  input wire logic TX_CORE_I,
  input wire logic BUS_TX_PIN_O,
  input wire logic CORE_ABORT_O,
  input wire logic CORE_RUN_O,
  input wire logic SLEEP_O
);
  // ==========================================================================
  // Helper state
  logic wr_ctl0_q;         // Data phase of a control 0 write
  logic rd_stat_q;         // Data phase of a status read
  logic init_seen_q;       // Init seen since the core last ran
  logic [15:0] rec_cnt_q;  // Consecutive recessive cycles, saturating
  wire logic take = HSEL_I && HTRANS_I[1] && HREADY_I;
  // Tracks bus phases and idle length so timing can be judged at the ports
  always_ff @(posedge SYS_CLK_I)
  begin
    if (RST_I)
    begin
      wr_ctl0_q <= 1'b0;
      rd_stat_q <= 1'b0;
      init_seen_q <= 1'b0;
      rec_cnt_q <= 16'h0000;
    end
    else
    begin
      wr_ctl0_q <= take && HWRITE_I && HADDR_I[7:0] == CMR_OFS_CTL0;
      rd_stat_q <= take && !HWRITE_I && HADDR_I[7:0] == CMR_OFS_STAT;
      init_seen_q <= CORE_ABORT_O || (init_seen_q && !CORE_RUN_O);
      rec_cnt_q <= !BUS_RX_I ? 16'h0000 : (rec_cnt_q == 16'hffff ? rec_cnt_q : rec_cnt_q + 16'h0001);
    end
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  AST_BUS_OKAY: assert property (HREADYOUT_O && !HRESP_O)
    else $error("slave not ready or response not OKAY");
  AST_INIT_ABORT: assert property (wr_ctl0_q && HWDATA_I[0] |-> ##[1:2] CORE_ABORT_O)
    else $error("init request did not abort traffic");
  AST_ABORT_NOT_RUN: assert property (CORE_ABORT_O |-> !CORE_RUN_O)
    else $error("core runs while aborted");
  AST_TX_REC_INIT: assert property (CORE_ABORT_O |-> BUS_TX_PIN_O)
    else $error("tx pin dominant during init");
  AST_TX_REC_STOP: assert property (STOP_MODE_I |-> BUS_TX_PIN_O)
    else $error("tx pin dominant in stop mode");
  AST_SLEEP_IDLE: assert property ($rose(SLEEP_O) |-> !$past(RX_BUSY_I))
    else $error("sleep entered while receiving");
  AST_RESYNC: assert property ($rose(CORE_RUN_O) && init_seen_q |-> rec_cnt_q >= 16'(10 * BIT_CYC))
    else $error("core ran before idle bits seen");
  AST_ERR_KEPT: assert property (rd_stat_q |-> HRDATA_O[15:8] == $past(TX_ERR_CNT_I))
    else $error("error count not read back");
  AST_TX_PASS: assert property (CORE_RUN_O && !CORE_ABORT_O && !SLEEP_O && !STOP_MODE_I && !WAIT_MODE_I
    |-> BUS_TX_PIN_O == TX_CORE_I)
    else $error("tx pin does not follow core");
endmodule
bind cmr_mode_ctrl cmr_mode_ctrl_sva #(.BIT_CYC(BIT_CYC)) u_sva (
  .SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I),
  .HWRITE_I(HWRITE_I), .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
  .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .BUS_RX_I(BUS_RX_I), .RX_BUSY_I(RX_BUSY_I),
  .TX_ERR_CNT_I(TX_ERR_CNT_I), .STOP_MODE_I(STOP_MODE_I), .WAIT_MODE_I(WAIT_MODE_I),
  .TX_CORE_I(TX_CORE_I), .BUS_TX_PIN_O(BUS_TX_PIN_O), .CORE_ABORT_O(CORE_ABORT_O),
  .CORE_RUN_O(CORE_RUN_O), .SLEEP_O(SLEEP_O));

// ---- cmr_pkg.sv ----
// Package of register offsets, field positions, reset values and timing counts for the CAN mode-request block
package cmr_pkg;
  // ==========================================================================
  // Register byte addresses on the AHB-Lite slave
  localparam logic [7:0] CMR_OFS_CTL0 = 8'h00;   // Mode control 0
  localparam logic [7:0] CMR_OFS_CTL1 = 8'h04;   // Mode control 1 (acks in low bits)
  localparam logic [7:0] CMR_OFS_RXF = 8'h08;    // Receiver flags
  localparam logic [7:0] CMR_OFS_RXIE = 8'h0c;   // Receiver interrupt enables
  localparam logic [7:0] CMR_OFS_TXF = 8'h10;    // Transmitter flags
  localparam logic [7:0] CMR_OFS_TXIE = 8'h14;   // Transmitter interrupt enables
  localparam logic [7:0] CMR_OFS_TARQ = 8'h18;   // Transmit abort request
  localparam logic [7:0] CMR_OFS_TAAK = 8'h1c;   // Transmit abort acknowledge
  localparam logic [7:0] CMR_OFS_TBSEL = 8'h20;  // Transmit buffer select
  localparam logic [7:0] CMR_OFS_BT0 = 8'h24;    // Bit timing 0
  localparam logic [7:0] CMR_OFS_BT1 = 8'h28;    // Bit timing 1
  localparam logic [7:0] CMR_OFS_IDAC = 8'h2c;   // Identifier acceptance control
  localparam logic [7:0] CMR_OFS_IDAR = 8'h40;   // Acceptance regs 0..7 at 0x40..0x5c
  localparam logic [7:0] CMR_OFS_IDMR = 8'h60;   // Mask regs 0..7 at 0x60..0x7c
  localparam logic [7:0] CMR_OFS_STAT = 8'h80;   // Block status (read only)
  // ==========================================================================
  // Field positions
  localparam int CMR_B_INIT_REQUEST = 0;   // Control 0: init request
  localparam int CMR_B_SLEEP_REQUEST = 1;    // Control 0: sleep request
  localparam int CMR_B_WAKEUP_ENABLE = 2;     // Control 0: wake-up enable
  localparam int CMR_B_INIT_ACK = 0;   // Control 1: init acknowledge
  localparam int CMR_B_SLEEP_ACK = 1;    // Control 1: sleep acknowledge
  localparam int CMR_B_WAKEUP_IRQ_FLAG = 7;    // Rx flags: wake-up interrupt flag
  localparam int CMR_B_WAKEUP_IRQ_ENABLE = 7;    // Rx enables: wake-up interrupt enable
  // Status field masks kept across initialization (bits 5:2 of rx and tx status)
  localparam logic [7:0] CMR_STAT_MASK = 8'h3c;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] CMR_RST_CTL0 = 8'h00;
  localparam logic [7:0] CMR_RST_CTL1 = 8'h11;   // Init ack set: out of reset in init mode
  localparam logic [7:0] CMR_RST_TXF = 8'h07;    // All three transmit buffers empty
  localparam logic [7:0] CMR_RST_ZERO = 8'h00;
  // ==========================================================================
  // Timing
  localparam int CMR_IDLE_BITS = 11;             // Recessive bits that mark bus idle
  localparam int CMR_BUSOFF_RUNS = 128;          // Idle runs needed when bus-off
  localparam int CMR_CLK_HZ = 50000000;
  localparam int CMR_BIT_RATE = 500000;          // Default bit rate for the sample enable
  localparam int CMR_BIT_CYC = CMR_CLK_HZ / CMR_BIT_RATE;
endpackage

// ---- test_can_mode_request_control.sv ----
// Self-checking testbench for the CAN mode-request block
`timescale 1ns/10ps
module test_can_mode_request_control;
  import cmr_pkg::*;
  localparam int BC = 4;        // Short bit time keeps resync waits brief
  localparam int LIMIT = 20000; // Cycle ceiling, several times the expected run
  typedef struct {logic wr; logic [7:0] adr; logic [31:0] val;} cmr_row_t;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rx_busy = 1'b0, bus_off = 1'b0;
  logic stop_m = 1'b0, wait_m = 1'b0, tx_core = 1'b1, node_start = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic [7:0] tx_err = 8'h3c, rx_err = 8'h00, tx_stat = 8'h14, node_bits = 8'h04;
  logic hready, hresp, bus_rx, tx_pin, abort, run, sleep, node_busy;
  int mismatches = 0, check_count = 0, cycles = 0;
  // Ordinary accesses in init mode out of reset: four reads, then three writes each followed by a read, each read with its expected value
  cmr_row_t rows [10] = '{
    '{1'b0, CMR_OFS_CTL0, 32'h01}, '{1'b0, CMR_OFS_CTL1, 32'h11}, '{1'b0, CMR_OFS_TXF, 32'h07},
    '{1'b0, CMR_OFS_STAT, 32'h3c04}, '{1'b1, CMR_OFS_BT1, 32'h3a}, '{1'b0, CMR_OFS_BT1, 32'h3a},
    '{1'b1, 8'h7c, 32'h77}, '{1'b0, 8'h7c, 32'h77}, '{1'b1, 8'h30, 32'hff}, '{1'b0, 8'h30, 32'h00}};
  // ==========================================================================
  // Design, far-side node and clock
  cmr_mode_ctrl #(.BIT_CYC(BC)) dut (.SYS_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .BUS_RX_I(bus_rx), .RX_BUSY_I(rx_busy),
    .BUS_OFF_I(bus_off), .TX_ERR_CNT_I(tx_err), .RX_ERR_CNT_I(rx_err), .TX_STAT_I(tx_stat),
    .STOP_MODE_I(stop_m), .WAIT_MODE_I(wait_m), .TX_CORE_I(tx_core), .BUS_TX_PIN_O(tx_pin),
    .CORE_ABORT_O(abort), .CORE_RUN_O(run), .SLEEP_O(sleep));
  cmr_bus_node #(.BIT_CYC(BC)) node (.clk_i(clk), .rst_i(rst), .tx_pin_i(tx_pin), .start_i(node_start),
    .bits_i(node_bits), .rx_o(bus_rx), .busy_o(node_busy));
  initial
  begin
    forever #10 clk = ~clk;
  end
  // ==========================================================================
  // Tasks
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One single word transfer; address phase held until ready, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  // Far node sends a burst of n bits
  task automatic burst(input logic [7:0] n);
    @(posedge clk) begin node_bits <= n; node_start <= 1'b1; end
    @(posedge clk) node_start <= 1'b0;
  endtask
  // Leaves init and waits, bounded, for the core to run
  task automatic exit_init(input logic [31:0] v);
    ahb(1'b1, CMR_OFS_CTL0, v);
    burst(8'd6);
    for (int i = 0; i < 400 && run !== 1'b1; i++) @(posedge clk);
    chk(run, 1'b1);
  endtask
  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      ahb(rows[i].wr, rows[i].adr, rows[i].val);
      if (!rows[i].wr)
        chk(rd, rows[i].val);
    end
    $display("test table done");
    exit_init(32'h00);
    ahb(1'b0, CMR_OFS_CTL1, 32'h0);
    chk(rd & 32'h03, 32'h0);
    ahb(1'b1, CMR_OFS_BT1, 32'h00);
    rd_chk(CMR_OFS_BT1, 32'h3a);
    ahb(1'b1, CMR_OFS_RXIE, 32'h80);
    rd_chk(CMR_OFS_RXIE, 32'h80);
    stop_m <= 1'b1;
    tx_core <= 1'b0;
    @(posedge clk);
    chk(tx_pin, 1'b1);
    stop_m <= 1'b0;
    tx_core <= 1'b1;
    $display("test exit and lock done");
    // Sleep held off while receiving, clear ignored until acknowledged
    rx_busy <= 1'b1;
    ahb(1'b1, CMR_OFS_CTL0, 32'h02);
    repeat (20) @(posedge clk);
    chk(sleep, 1'b0);
    ahb(1'b1, CMR_OFS_CTL0, 32'h00);
    rd_chk(CMR_OFS_CTL0, 32'h02);
    rx_busy <= 1'b0;
    for (int i = 0; i < 200 && sleep !== 1'b1; i++) @(posedge clk);
    chk(sleep, 1'b1);
    tx_core <= 1'b0;
    @(posedge clk);
    chk(tx_pin, 1'b1);
    tx_core <= 1'b1;
    ahb(1'b0, CMR_OFS_CTL1, 32'h0);
    chk(rd[1], 1'b1);
    // Wake by bus activity, then a pending wake flag blocks a new request
    ahb(1'b1, CMR_OFS_CTL0, 32'h06);
    burst(8'd4);
    for (int i = 0; i < 200 && sleep !== 1'b0; i++) @(posedge clk);
    chk(sleep, 1'b0);
    rd_chk(CMR_OFS_CTL0, 32'h04);
    ahb(1'b1, CMR_OFS_CTL0, 32'h06);
    rd_chk(CMR_OFS_CTL0, 32'h04);
    ahb(1'b1, CMR_OFS_RXF, 32'h80);
    ahb(1'b1, CMR_OFS_CTL0, 32'h06);
    rd_chk(CMR_OFS_CTL0, 32'h06);
    ahb(1'b1, CMR_OFS_CTL0, 32'h04);
    $display("test sleep and wake done");
    // Init request from run: abort, recessive pin, partial register reset
    tx_core <= 1'b0;
    tx_err <= 8'h5a;
    ahb(1'b1, CMR_OFS_CTL0, 32'h05);
    @(posedge clk);
    chk(abort, 1'b1);
    chk(tx_pin, 1'b1);
    repeat (8) @(posedge clk);
    ahb(1'b0, CMR_OFS_CTL1, 32'h0);
    chk(rd[0], 1'b1);
    rd_chk(CMR_OFS_RXIE, 32'h00);
    rd_chk(CMR_OFS_CTL0, 32'h05);
    rd_chk(CMR_OFS_RXF, 32'h14);
    ahb(1'b0, CMR_OFS_STAT, 32'h0);
    chk(rd[15:8], 8'h5a);
    ahb(1'b1, CMR_OFS_CTL1, 32'h20);
    tx_core <= 1'b1;
    // Bus-off exit: one idle run is not enough, 128 runs are
    bus_off <= 1'b1;
    ahb(1'b1, CMR_OFS_CTL0, 32'h04);
    repeat (200) @(posedge clk);
    chk(run, 1'b0);
    for (int i = 0; i < 6000 && run !== 1'b1; i++) @(posedge clk);
    chk(run, 1'b1);
    bus_off <= 1'b0;
    tx_core <= 1'b0;
    wait_m <= 1'b1;
    @(posedge clk);
    chk(tx_pin, 1'b1);
    $display("test init and wait done");
    end_sim();
  end
endmodule
